// ---- design/pst_pkg.sv ----
// Package with command codes, bit positions and reset values of the status and telemetry bank.
package pst_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_IIN = 8'h89;
    localparam logic [7:0] CMD_VOUT = 8'h8B;
    // ------------------------------------------------------------
    // Vendor status bit positions
    // ------------------------------------------------------------
    localparam int BIT_PHASE_FAIL = 6;
    localparam int BIT_IDSB_ERROR = 4;
    localparam int BIT_SYNC_LOST = 3;
    localparam int BIT_FAULT_GROUP = 2;
    localparam int BIT_FAULT_BUS = 0;
    localparam logic [7:0] VENDOR_USED_MASK = 8'h5D;
    // ------------------------------------------------------------
    // Communication error status bit positions
    // ------------------------------------------------------------
    localparam int CML_BAD_CMD = 7;
    localparam int CML_WRITE_RO = 1;
    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] VENDOR_RESET = 8'h00;
    localparam logic [7:0] CML_RESET = 8'h00;
    localparam logic [15:0] READING_RESET = 16'h0000;
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    localparam int DUTY_SHIFT = 8;
    localparam int CALC_LATENCY = 2;
endpackage

// ---- design/pst_calc_if.sv ----
// Interface joining the bank to its input current calculator.
`timescale 1ns/1ps
`default_nettype none
interface pst_calc_if;
    logic start;
    logic signed [10:0] iout_mant;
    logic [4:0] iout_exp;
    logic [7:0] duty;
    logic signed [10:0] trim;
    logic done;
    logic [15:0] result;
    modport req (output start, iout_mant, iout_exp, duty, trim, input done, result);
    modport unit (input start, iout_mant, iout_exp, duty, trim, output done, result);
endinterface
`default_nettype wire

// ---- design/pst_iin_calc.sv ----
// Two-stage calculator of the input current reading from output current, duty and trim.
`timescale 1ns/1ps
`default_nettype none
module pst_iin_calc (
    input wire logic clk,
    input wire logic rst_n,
    pst_calc_if.unit calc
);
    logic signed [19:0] prod;
    logic [4:0] exp_s1;
    logic signed [10:0] trim_s1;
    logic valid_s1;
    logic signed [12:0] next_sum;
    logic [10:0] next_mant;

    // ------------------------------------------------------------
    // Stage one scales the output current by the duty fraction.
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prod <= '0;
            exp_s1 <= '0;
            trim_s1 <= '0;
            valid_s1 <= 1'b0;
        end else begin
            valid_s1 <= calc.start;
            if (calc.start) begin
                prod <= calc.iout_mant * $signed({1'b0, calc.duty});
                exp_s1 <= calc.iout_exp;
                trim_s1 <= calc.trim;
            end
        end
    end

    // ------------------------------------------------------------
    // Stage two adds the trim and saturates to the mantissa range.
    // ------------------------------------------------------------
    always_comb begin
        next_sum = {prod[19], prod[19:pst_pkg::DUTY_SHIFT]} + {{2{trim_s1[10]}}, trim_s1};
        if (next_sum[12:10] == 3'b000 || next_sum[12:10] == 3'b111) begin
            next_mant = next_sum[10:0];
        end else if (next_sum[12]) begin
            next_mant = 11'h400;
        end else begin
            next_mant = 11'h3FF;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calc.result <= pst_pkg::READING_RESET;
            calc.done <= 1'b0;
        end else begin
            calc.done <= valid_s1;
            if (valid_s1) begin
                calc.result <= {exp_s1, next_mant};
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/pst_status_bank.sv ----
// Status and telemetry register bank reached by PMBus command code.
// ------------------------------------------------------------
// Overview of operation
// - Vendor status is one read-only byte, all zero after reset.
// - Bit 6 sets when a current-share group member fails while sharing.
// - Bit 4 sets on an inter-device serial bus error.
// - Bit 3 sets when external clock synchronisation is lost.
// - Bit 2 sets when a fault arrives through the fault group.
// - Bit 0 sets on shutdown by the enable pin used as fault line.
// - Input voltage command returns two-byte exponent-mantissa value in volts.
// - Input current is computed from output current, duty and calibration trim.
// - Input current reading may be inaccurate in diode emulation mode.
// - Output voltage command returns unsigned two bytes scaled by two to minus 13.
// - Writes to these read-only registers are refused and set communication bit 1.
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pst_status_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic clear_faults,
    input wire logic share_member,
    input wire logic enable_fault_bus_mode,
    input wire logic phase_fail_evt,
    input wire logic idsb_error_evt,
    input wire logic sync_lost_evt,
    input wire logic fault_group_evt,
    input wire logic fault_bus_shutdown_evt,
    input wire logic telem_valid,
    input wire logic [15:0] vin_value,
    input wire logic [15:0] iout_value,
    input wire logic [15:0] vout_value,
    input wire logic [7:0] duty_frac,
    input wire logic [10:0] input_current_cal_trim,
    input wire logic diode_emulation_mode,
    output logic rd_valid,
    output logic rd_two_bytes,
    output logic [15:0] rd_data,
    output logic [7:0] communication_error_status,
    output logic iin_inaccurate
);
    logic [7:0] vendor_status;
    logic [15:0] vin_reg;
    logic [15:0] iin_reg;
    logic [15:0] vout_reg;
    logic [7:0] next_set;
    logic is_mapped;
    pst_calc_if calc_bus ();

    // ------------------------------------------------------------
    // Command decode.
    // ------------------------------------------------------------
    always_comb begin
        if (cmd_code == pst_pkg::CMD_VENDOR_STATUS) begin
            is_mapped = 1'b1;
        end else if (cmd_code == pst_pkg::CMD_VIN) begin
            is_mapped = 1'b1;
        end else if (cmd_code == pst_pkg::CMD_IIN) begin
            is_mapped = 1'b1;
        end else if (cmd_code == pst_pkg::CMD_VOUT) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Vendor status flags; a new event wins over a clear.
    // ------------------------------------------------------------
    always_comb begin
        next_set = 8'h00;
        next_set[pst_pkg::BIT_PHASE_FAIL] = phase_fail_evt && share_member;
        next_set[pst_pkg::BIT_IDSB_ERROR] = idsb_error_evt;
        next_set[pst_pkg::BIT_SYNC_LOST] = sync_lost_evt;
        next_set[pst_pkg::BIT_FAULT_GROUP] = fault_group_evt;
        next_set[pst_pkg::BIT_FAULT_BUS] = fault_bus_shutdown_evt && enable_fault_bus_mode;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vendor_status <= pst_pkg::VENDOR_RESET;
        end else if (clear_faults) begin
            vendor_status <= next_set & pst_pkg::VENDOR_USED_MASK;
        end else begin
            vendor_status <= (vendor_status | next_set) & pst_pkg::VENDOR_USED_MASK;
        end
    end

    // ------------------------------------------------------------
    // Communication error flags.
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            communication_error_status <= pst_pkg::CML_RESET;
        end else begin
            if (clear_faults) begin
                communication_error_status <= pst_pkg::CML_RESET;
            end
            if (cmd_valid && cmd_write && is_mapped) begin
                communication_error_status[pst_pkg::CML_WRITE_RO] <= 1'b1;
            end
            if (cmd_valid && !is_mapped) begin
                communication_error_status[pst_pkg::CML_BAD_CMD] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Telemetry capture.
    // ------------------------------------------------------------
    assign calc_bus.start = telem_valid;
    assign calc_bus.iout_mant = iout_value[pst_pkg::MANT_MSB:0];
    assign calc_bus.iout_exp = iout_value[pst_pkg::EXP_MSB:pst_pkg::EXP_LSB];
    assign calc_bus.duty = duty_frac;
    assign calc_bus.trim = input_current_cal_trim;

    pst_iin_calc u_calc (
        .clk(clk),
        .rst_n(rst_n),
        .calc(calc_bus.unit)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vin_reg <= pst_pkg::READING_RESET;
            vout_reg <= pst_pkg::READING_RESET;
        end else if (telem_valid) begin
            vin_reg <= vin_value;
            vout_reg <= vout_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            iin_reg <= pst_pkg::READING_RESET;
            iin_inaccurate <= 1'b0;
        end else if (calc_bus.done) begin
            iin_reg <= calc_bus.result;
            iin_inaccurate <= diode_emulation_mode;
        end
    end

    // ------------------------------------------------------------
    // Read answer; writes return nothing and change no reading.
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_two_bytes <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= cmd_valid && !cmd_write;
            rd_two_bytes <= 1'b0;
            rd_data <= 16'h0000;
            if (cmd_valid && !cmd_write) begin
                if (cmd_code == pst_pkg::CMD_VENDOR_STATUS) begin
                    rd_data <= {8'h00, vendor_status};
                end else if (cmd_code == pst_pkg::CMD_VIN) begin
                    rd_data <= vin_reg;
                    rd_two_bytes <= 1'b1;
                end else if (cmd_code == pst_pkg::CMD_IIN) begin
                    rd_data <= iin_reg;
                    rd_two_bytes <= 1'b1;
                end else if (cmd_code == pst_pkg::CMD_VOUT) begin
                    rd_data <= vout_reg;
                    rd_two_bytes <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_status_reset_zero: assert property ($rose(rst_n) |-> vendor_status == 8'h00)
        else $error("Vendor status not zero after reset.");
    a_phase_fail_set: assert property (phase_fail_evt && share_member |=> vendor_status[6])
        else $error("Phase fail flag not set.");
    a_phase_needs_share: assert property (
        !vendor_status[6] && !share_member |=> !vendor_status[6])
        else $error("Phase fail flag set outside sharing.");
    a_idsb_err_set: assert property (idsb_error_evt |=> vendor_status[4] [*1])
        else $error("Serial bus error flag not set.");
    a_sync_lost_set: assert property (sync_lost_evt |=> vendor_status[3])
        else $error("Sync lost flag not set.");
    a_fault_group_set: assert property (fault_group_evt |=> vendor_status[2])
        else $error("Fault group flag not set.");
    a_fault_bus_set: assert property (
        fault_bus_shutdown_evt && enable_fault_bus_mode |=> vendor_status[0])
        else $error("Fault bus flag not set.");
    a_unused_bits_zero: assert property (
        vendor_status[7] == 1'b0 && vendor_status[5] == 1'b0 && vendor_status[1] == 1'b0)
        else $error("Unused status bit is set.");
    a_vin_read_value: assert property (
        cmd_valid && !cmd_write && cmd_code == 8'h88 |=> rd_valid && rd_two_bytes
        && rd_data == $past(vin_reg))
        else $error("Input voltage read wrong.");
    a_iin_follows_calc: assert property (
        telem_valid |-> ##3 iin_reg == $past(calc_bus.result))
        else $error("Input current reading not updated by calculator.");
    a_vout_read_value: assert property (
        cmd_valid && !cmd_write && cmd_code == 8'h8B |=> rd_valid && rd_two_bytes
        && rd_data == $past(vout_reg))
        else $error("Output voltage read wrong.");
    a_iin_read_value: assert property (
        cmd_valid && !cmd_write && cmd_code == 8'h89 |=> rd_valid && rd_two_bytes
        && rd_data == $past(iin_reg))
        else $error("Input current read wrong.");
    a_status_read_value: assert property (
        cmd_valid && !cmd_write && cmd_code == 8'h80 |=> rd_valid && !rd_two_bytes
        && rd_data == {8'h00, $past(vendor_status)})
        else $error("Vendor status read wrong.");
    a_ro_write_flag: assert property (
        cmd_valid && cmd_write && is_mapped |=> communication_error_status[1]
        && !rd_valid && ($stable(vin_reg) || $past(telem_valid)) [*1])
        else $error("Read-only write not flagged.");

    c_status_read: cover property (cmd_valid && !cmd_write && cmd_code == 8'h80 && vendor_status != 8'h00);
    c_iin_update: cover property (telem_valid ##3 cmd_valid && !cmd_write && cmd_code == 8'h89);
    c_ro_write: cover property (cmd_valid && cmd_write && cmd_code == 8'h88);
    c_set_over_clear: cover property (clear_faults && idsb_error_evt);
endmodule
`default_nettype wire

// ---- tb/pst_host_model.sv ----
// Host side model that issues reads and write attempts by command code.
`timescale 1ns/1ps
`default_nettype none
module pst_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    input wire logic rd_valid,
    input wire logic rd_two_bytes,
    input wire logic [15:0] rd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
    end
    // ------------------------------------------------------------
    // One command, answer sampled 1 ns after the clock edge that takes it.
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] code, output logic got,
                        output logic two, output logic [15:0] data);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_code = ~code;
        got = rd_valid;
        two = rd_two_bytes;
        data = rd_data;
    endtask
endmodule
`default_nettype wire

// ---- tb/pst_status_bank_tb.sv ----
// Self-checking testbench of the status and telemetry bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t ns: got %h, want %h", $time, a, b); end end
module pst_status_bank_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, cmd_write, rd_valid, rd_two_bytes, iin_inaccurate, got, two;
    logic [7:0] cmd_code, communication_error_status, expv;
    logic clear_faults = 1'b0, share_member = 1'b0, enable_fault_bus_mode = 1'b0;
    logic telem_valid = 1'b0, diode_emulation_mode = 1'b0;
    logic [4:0] evt = 5'h00;
    logic [7:0] duty_frac = 8'h00;
    logic [15:0] vin_value = 16'h0000, iout_value = 16'h0000, vout_value = 16'h0000;
    logic [15:0] rd_data, data;
    logic [10:0] input_current_cal_trim = 11'h000;
    logic [31:0] seed = 32'h00011F0F;
    logic [31:0] r;
    int fails = 0, compares = 0;
    int bit_pos [5] = '{pst_pkg::BIT_PHASE_FAIL, pst_pkg::BIT_IDSB_ERROR,
        pst_pkg::BIT_SYNC_LOST, pst_pkg::BIT_FAULT_GROUP, pst_pkg::BIT_FAULT_BUS};
    logic [7:0] ro_codes [4] = '{pst_pkg::CMD_VENDOR_STATUS, pst_pkg::CMD_VIN,
        pst_pkg::CMD_IIN, pst_pkg::CMD_VOUT};

    always #2.5 clk = ~clk;

    pst_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .rd_valid(rd_valid), .rd_two_bytes(rd_two_bytes),
        .rd_data(rd_data));

    pst_status_bank i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .clear_faults(clear_faults),
        .share_member(share_member), .enable_fault_bus_mode(enable_fault_bus_mode),
        .phase_fail_evt(evt[0]), .idsb_error_evt(evt[1]), .sync_lost_evt(evt[2]),
        .fault_group_evt(evt[3]), .fault_bus_shutdown_evt(evt[4]),
        .telem_valid(telem_valid), .vin_value(vin_value), .iout_value(iout_value),
        .vout_value(vout_value), .duty_frac(duty_frac),
        .input_current_cal_trim(input_current_cal_trim),
        .diode_emulation_mode(diode_emulation_mode), .rd_valid(rd_valid),
        .rd_two_bytes(rd_two_bytes), .rd_data(rd_data),
        .communication_error_status(communication_error_status),
        .iin_inaccurate(iin_inaccurate));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [15:0] iin_expect(logic [15:0] io, logic [7:0] d, logic [10:0] t);
        int s;
        s = ((int'($signed(io[10:0])) * int'(d)) >>> 8) + int'($signed(t));
        if (s > 1023) s = 1023;
        if (s < -1024) s = -1024;
        return {io[15:11], 11'(s)};
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic wr, input logic [7:0] code);
        i_host.xfer(wr, code, got, two, data);
    endtask

    task automatic clear();
        clear_faults = 1'b1;
        tick();
        clear_faults = 1'b0;
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        cmd(1'b0, pst_pkg::CMD_VENDOR_STATUS);
        `CHK(data, 16'h0000)
        `CHK(communication_error_status, 8'h00)
        for (int k = 0; k < 10; k++) begin
            int j;
            j = k % 5;
            share_member = (k < 5);
            enable_fault_bus_mode = (k >= 5);
            clear();
            evt = 5'h01 << j;
            tick();
            evt = 5'h00;
            expv = 8'h01 << bit_pos[j];
            if ((j == 0 && !share_member) || (j == 4 && !enable_fault_bus_mode)) expv = 8'h00;
            cmd(1'b0, pst_pkg::CMD_VENDOR_STATUS);
            `CHK(data, {8'h00, expv})
            `CHK(two, 1'b0)
        end
        share_member = 1'b1;
        enable_fault_bus_mode = 1'b1;
        evt = 5'h1F;
        clear();
        evt = 5'h00;
        cmd(1'b0, pst_pkg::CMD_VENDOR_STATUS);
        `CHK(data, 16'h005D)
        rst_n = 1'b0;
        repeat (2) tick();
        rst_n = 1'b1;
        cmd(1'b0, pst_pkg::CMD_VENDOR_STATUS);
        `CHK(data, 16'h0000)
        for (int i = 0; i < 10; i++) begin
            r = xorshift();
            vin_value = r[15:0];
            vout_value = r[31:16];
            r = xorshift();
            iout_value = r[15:0];
            duty_frac = r[23:16];
            input_current_cal_trim = r[31:21];
            diode_emulation_mode = r[20];
            if (i == 0) begin
                iout_value = 16'h03FF;
                duty_frac = 8'hFF;
                input_current_cal_trim = 11'h3FF;
            end
            if (i == 1) begin
                iout_value = 16'h0400;
                duty_frac = 8'hFF;
                input_current_cal_trim = 11'h400;
            end
            telem_valid = 1'b1;
            tick();
            telem_valid = 1'b0;
            repeat (3) tick();
            cmd(1'b0, pst_pkg::CMD_IIN);
            `CHK(data, iin_expect(iout_value, duty_frac, input_current_cal_trim))
            `CHK(iin_inaccurate, diode_emulation_mode)
            cmd(1'b0, pst_pkg::CMD_VIN);
            `CHK(data, vin_value)
            `CHK(two, 1'b1)
            cmd(1'b0, pst_pkg::CMD_VOUT);
            `CHK(data, vout_value)
        end
        for (int k = 0; k < 4; k++) begin
            clear();
            cmd(1'b1, ro_codes[k]);
            `CHK(got, 1'b0)
            `CHK(communication_error_status, 8'h02)
        end
        cmd(1'b0, 8'h8A);
        `CHK({got, data}, 17'h10000)
        `CHK(communication_error_status, 8'h82)
        test_done();
    end

    initial begin
        #(20000 * 5);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
